// ---- tb.sv ----
// Testbench for uopc_top: register table, reset, refusals, busy, activity.
// Assumes uopc_top, uopc_peer_model and the bound checker are compiled.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic core_clk = 1'b0, reset_n = 1'b0, regWrite = 1'b0, regRead = 1'b0, actGo = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0, regRdata;
    logic [3:0] hwResistorCtl = 4'h0;
    logic busActivity, notifyPending, irqGenerated, sleepBlock;
    wire [10:0] outs;
    int failures = 0, checks = 0;
    logic [7:0] rowOtg[5] = '{8'hFF, 8'h88, 8'h54, 8'hFF, 8'h0A};
    logic [7:0] rowPwr[5] = '{8'h01, 8'h01, 8'hEB, 8'h00, 8'h01};
    logic [7:0] rowRd[5]  = '{8'h09, 8'h09, 8'h0B, 8'h00, 8'h09};
    logic [3:0] rowHw[5]  = '{4'h0, 4'h5, 4'h0, 4'h0, 4'hA};
    logic [10:0] rowOut[5] = '{11'h7FB, 11'h2CB, 11'h287, 11'h004, 11'h56B};
    always #2.5 core_clk = ~core_clk;
    uopc_top #(.SETTLE_CYCLES(2)) DUT (.core_clk, .reset_n, .regAddr, .regWdata, .regWrite,
        .regRead, .regRdata, .hwResistorCtl, .busActivity, .notifyPending, .irqGenerated,
        .dplusPullupEn(outs[10]), .dminusPullupEn(outs[9]), .dplusPulldownEn(outs[8]),
        .dminusPulldownEn(outs[7]), .busSupplyOn(outs[6]), .busSupplyChargeEn(outs[5]),
        .busSupplyDischargeEn(outs[4]), .usbClkEn(outs[3]), .xcvrLowPower(outs[2]),
        .pinsUsbOwned(outs[1]), .analogEn(outs[0]), .sleepBlock(sleepBlock));
    uopc_peer_model #(.IRQ_DELAY(6)) peer (.core_clk, .reset_n, .actGo, .busActivity,
        .notifyPending, .irqGenerated);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        @(negedge core_clk);
        chk(regRdata, {24'h0, exp}, "read data");
    endtask : rd
    task automatic print_verdict;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : print_verdict
    // Watchdog
    initial begin
        #25000;
        failures++;
        print_verdict();
    end
    initial begin
        repeat (4) @(posedge core_clk);
        reset_n <= 1'b1;
        @(negedge core_clk);
        chk({21'h0, outs}, 32'h004, "reset outputs");
        rd(8'h00, 8'h00);
        rd(8'h04, 8'h00);
        // Table rows: writes with junk in the upper bytes, outputs, read-back
        for (int i = 0; i < 5; i++) begin
            @(posedge core_clk);
            hwResistorCtl <= rowHw[i];
            wr(8'h00, {24'hFFFFFF, rowOtg[i]});
            wr(8'h04, {24'hA5A5A5, rowPwr[i]});
            repeat (4) @(posedge core_clk);
            @(negedge core_clk);
            chk({21'h0, outs}, {21'h0, rowOut[i]}, "pin outputs");
            rd(8'h00, rowOtg[i]);
            rd(8'h04, rowRd[i]);
        end
        // Unmapped place is refused
        wr(8'h08, 32'hFFFFFFFF);
        rd(8'h08, 8'h00);
        rd(8'h00, 8'h0A);
        // Busy holds after power-off until the settle time runs out
        wr(8'h04, 32'h0);
        rd(8'h04, 8'h08);
        repeat (3) @(posedge core_clk);
        rd(8'h04, 8'h00);
        // Activity with the guard set, then the interrupt clears pending
        wr(8'h04, 32'h11);
        @(posedge core_clk);
        actGo <= 1'b1;
        @(posedge core_clk);
        actGo <= 1'b0;
        rd(8'h04, 8'h99);
        chk({31'h0, sleepBlock}, 32'h1, "sleep not blocked");
        repeat (8) @(posedge core_clk);
        rd(8'h04, 8'h19);
        chk({31'h0, sleepBlock}, 32'h0, "sleep blocked when idle");
        // Reset in mid-run clears both registers and every output except xcvrLowPower, which is set
        @(posedge core_clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        @(negedge core_clk);
        chk({21'h0, outs}, 32'h004, "outputs after reset");
        chk({31'h0, sleepBlock}, 32'h0, "sleep after reset");
        rd(8'h00, 8'h00);
        rd(8'h04, 8'h00);
        print_verdict();
    end
endmodule : tb
`default_nettype wire

// ---- uopc_act_if.sv ----
// Carrier between the control core and the bus activity tracker.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
`default_nettype none
interface uopc_act_if;
    logic busActivity;   // Bus activity seen this cycle
    logic notifyPending; // Notification awaiting service
    logic irqGenerated;  // Activity interrupt issued by the USB core
    logic enable;        // Module powered
    logic sleepGuard;    // Sleep guard bit
    logic pending;       // Activity pending flag
    logic sleepBlock;    // Sleep entry is blocked

    modport ctrl (
        output busActivity, notifyPending, irqGenerated, enable, sleepGuard,
        input  pending, sleepBlock
    );
    modport trk (
        input  busActivity, notifyPending, irqGenerated, enable, sleepGuard,
        output pending, sleepBlock
    );
endinterface : uopc_act_if
`default_nettype wire

// ---- uopc_activity_tracker.sv ----
// Activity pending flag and sleep guard of the USB power control block.
// Assumes its controls come through uopc_act_if on core_clk.
`timescale 1ns/1ps
`default_nettype none
module uopc_activity_tracker (
    input  wire logic core_clk,
    input  wire logic reset_n,
    uopc_act_if.trk   act
);
    typedef struct packed {
        logic pending;
    } uopc_trk_s;

    uopc_trk_s state_q;
    uopc_trk_s state_d;

    // Set on activity, cleared once its interrupt is out; set wins
    always_comb begin
        state_d = state_q;
        if (!act.enable) begin
            state_d.pending = 1'b0;
        end else if (act.busActivity) begin
            state_d.pending = 1'b1;
        end else if (act.irqGenerated) begin
            state_d.pending = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // Sleep blocked only while guarded and something is going on
    assign act.pending    = state_q.pending;
    assign act.sleepBlock = act.sleepGuard
                          & (act.busActivity | state_q.pending | act.notifyPending);
endmodule : uopc_activity_tracker
`default_nettype wire

// ---- uopc_peer_model.sv ----
// Bus peer: on a go pulse shows one cycle of activity, holds a
// notification, then the interrupt pulse after IRQ_DELAY cycles.
`timescale 1ns/1ps
`default_nettype none
module uopc_peer_model #(
    parameter int IRQ_DELAY = 6
) (
    input  wire logic core_clk,
    input  wire logic reset_n,
    input  wire logic actGo,
    output logic      busActivity,
    output logic      notifyPending,
    output logic      irqGenerated
);
    logic [7:0] waitCnt_q;
    // Activity, notification and delayed interrupt
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            busActivity   <= 1'b0;
            notifyPending <= 1'b0;
            irqGenerated  <= 1'b0;
            waitCnt_q     <= 8'h00;
        end else begin
            busActivity   <= actGo;
            irqGenerated  <= (waitCnt_q == 8'h01);
            notifyPending <= actGo || (waitCnt_q > 8'h01);
            if (actGo) begin
                waitCnt_q <= IRQ_DELAY[7:0];
            end else if (waitCnt_q != 8'h00) begin
                waitCnt_q <= waitCnt_q - 8'h01;
            end
        end
    end
endmodule : uopc_peer_model
`default_nettype wire

// ---- uopc_pkg.sv ----
// Constants for the USB on-the-go power control block.
// Assumes a 200 MHz core clock and the plain register port of uopc_top.
package uopc_pkg;

    // Register offsets on the register port (byte addresses)
    localparam logic [7:0] OTG_CTRL_OFS  = 8'h00;
    localparam logic [7:0] PWR_CTRL_OFS  = 8'h04;
    localparam int         ADDR_W        = 8;
    localparam int         DATA_W        = 32;

    // Field positions of otg_control_reg
    localparam int OTG_DPLUS_PU_BIT   = 7;
    localparam int OTG_DMINUS_PU_BIT  = 6;
    localparam int OTG_DPLUS_PD_BIT   = 5;
    localparam int OTG_DMINUS_PD_BIT  = 4;
    localparam int OTG_SUPPLY_ON_BIT  = 3;
    localparam int OTG_SW_CTL_BIT     = 2;
    localparam int OTG_CHARGE_BIT     = 1;
    localparam int OTG_DISCHARGE_BIT  = 0;

    // Field positions of usb_power_control_reg
    localparam int PWR_ACT_PEND_BIT   = 7;
    localparam int PWR_SLEEP_GRD_BIT  = 4;
    localparam int PWR_BUSY_BIT       = 3;
    localparam int PWR_SUSPEND_BIT    = 1;
    localparam int PWR_ON_BIT         = 0;

    // Reset values of both registers
    localparam logic [7:0] OTG_CTRL_RST  = 8'h00;
    localparam logic [7:0] PWR_CTRL_RST  = 8'h00;

    // Time from power-off until the module is ready to be enabled again
    localparam int CLK_MHZ        = 200;
    localparam int SETTLE_NS      = 100;
    localparam int SETTLE_CYCLES  = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int SETTLE_W       = 8;

endpackage : uopc_pkg

// ---- uopc_top.sv ----
// Control and status core of the USB on-the-go power control block.
// Assumes a 200 MHz core clock, a single-cycle register port with read
// data one cycle after the read strobe, and a USB core beside it.
`timescale 1ns/1ps
`default_nettype none
module uopc_top #(
    parameter int SETTLE_CYCLES = uopc_pkg::SETTLE_CYCLES
) (
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic      [31:0] regRdata,
    input  wire logic [3:0]  hwResistorCtl,
    input  wire logic        busActivity,
    input  wire logic        notifyPending,
    input  wire logic        irqGenerated,
    output logic             dplusPullupEn,
    output logic             dminusPullupEn,
    output logic             dplusPulldownEn,
    output logic             dminusPulldownEn,
    output logic             busSupplyOn,
    output logic             busSupplyChargeEn,
    output logic             busSupplyDischargeEn,
    output logic             usbClkEn,
    output logic             xcvrLowPower,
    output logic             pinsUsbOwned,
    output logic             analogEn,
    output logic             sleepBlock
);

    // Settle count at register width
    localparam logic [uopc_pkg::SETTLE_W-1:0] SETTLE_LOAD =
        uopc_pkg::SETTLE_W'(SETTLE_CYCLES);

    // All state of the core except the activity pending flag, which the tracker holds
    typedef struct packed {
        logic [7:0]                    otgCtrl;
        logic                          sleepGuard;
        logic                          suspendReq;
        logic                          powerOn;
        logic [uopc_pkg::SETTLE_W-1:0] settleCnt;
        logic [31:0]                   rdata;
        logic [3:0]                    resistorOut;
        logic                          supplyOnOut;
        logic                          chargeOut;
        logic                          dischargeOut;
        logic                          clkEnOut;
        logic                          lowPowerOut;
        logic                          pinsOwnedOut;
        logic                          analogOut;
    } uopc_core_s;

    uopc_core_s state_q;
    uopc_core_s state_d;

    // Link to the activity tracker
    uopc_act_if act ();

    // Register offset match
    function automatic logic regHit(
        input logic [7:0] addr,
        input logic [7:0] ofs
    );
        regHit = (addr == ofs);
    endfunction : regHit

    // Decoded strobes
    logic        wrOtg;
    logic        wrPwr;
    logic        rdOtg;
    logic        rdPwr;
    logic        busy;
    logic [3:0]  resistorSel;
    logic [7:0]  pwrView;

    assign wrOtg = regWrite & regHit(regAddr, uopc_pkg::OTG_CTRL_OFS);
    assign wrPwr = regWrite & regHit(regAddr, uopc_pkg::PWR_CTRL_OFS);
    assign rdOtg = regRead  & regHit(regAddr, uopc_pkg::OTG_CTRL_OFS);
    assign rdPwr = regRead  & regHit(regAddr, uopc_pkg::PWR_CTRL_OFS);

    // Busy while on, or while off but still settling
    assign busy = state_q.powerOn | (state_q.settleCnt != '0);

    // Software or USB hardware owns the data line resistors
    assign resistorSel = state_q.otgCtrl[uopc_pkg::OTG_SW_CTL_BIT]
                       ? state_q.otgCtrl[uopc_pkg::OTG_DPLUS_PU_BIT:uopc_pkg::OTG_DMINUS_PD_BIT]
                       : hwResistorCtl;

    // Power control register as software sees it
    always_comb begin
        pwrView = 8'h00;
        pwrView[uopc_pkg::PWR_ACT_PEND_BIT]  = act.pending;
        pwrView[uopc_pkg::PWR_SLEEP_GRD_BIT] = state_q.sleepGuard;
        pwrView[uopc_pkg::PWR_BUSY_BIT]      = busy;
        pwrView[uopc_pkg::PWR_SUSPEND_BIT]   = state_q.suspendReq;
        pwrView[uopc_pkg::PWR_ON_BIT]        = state_q.powerOn;
    end

    // Next state: register writes, settle timer, read data, pin outputs
    always_comb begin
        state_d = state_q;

        // Control register writes
        if (wrOtg) begin
            state_d.otgCtrl = regWdata[7:0];
        end
        if (wrPwr) begin
            state_d.sleepGuard = regWdata[uopc_pkg::PWR_SLEEP_GRD_BIT];
            state_d.suspendReq = regWdata[uopc_pkg::PWR_SUSPEND_BIT];
            state_d.powerOn    = regWdata[uopc_pkg::PWR_ON_BIT];
        end

        // Settle timer starts when the module is switched off
        if (state_q.powerOn && !state_d.powerOn) begin
            state_d.settleCnt = SETTLE_LOAD;
        end else if (state_q.settleCnt != '0) begin
            state_d.settleCnt = state_q.settleCnt - 1'b1;
        end

        // Read data stands only in the cycle after the strobe
        state_d.rdata = 32'h0000_0000;
        if (rdOtg) begin
            state_d.rdata[7:0] = state_q.otgCtrl;
        end else if (rdPwr) begin
            state_d.rdata[7:0] = pwrView;
        end

        // Pin and analog controls, all held inactive while off except xcvrLowPower, held high
        if (state_q.powerOn) begin
            state_d.resistorOut  = resistorSel;
            state_d.supplyOnOut  = state_q.otgCtrl[uopc_pkg::OTG_SUPPLY_ON_BIT];
            state_d.chargeOut    = state_q.otgCtrl[uopc_pkg::OTG_CHARGE_BIT];
            state_d.dischargeOut = state_q.otgCtrl[uopc_pkg::OTG_DISCHARGE_BIT];
            state_d.clkEnOut     = ~state_q.suspendReq;
            state_d.lowPowerOut  = state_q.suspendReq;
            state_d.pinsOwnedOut = 1'b1;
            state_d.analogOut    = 1'b1;
        end else begin
            state_d.resistorOut  = 4'h0;
            state_d.supplyOnOut  = 1'b0;
            state_d.chargeOut    = 1'b0;
            state_d.dischargeOut = 1'b0;
            state_d.clkEnOut     = 1'b0;
            state_d.lowPowerOut  = 1'b1;
            state_d.pinsOwnedOut = 1'b0;
            state_d.analogOut    = 1'b0;
        end
    end

    // State register
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q             <= '0;
            state_q.otgCtrl     <= uopc_pkg::OTG_CTRL_RST;
            state_q.lowPowerOut <= 1'b1;
        end else begin
            state_q <= state_d;
        end
    end

    // Activity tracker controls
    assign act.busActivity   = busActivity;
    assign act.notifyPending = notifyPending;
    assign act.irqGenerated  = irqGenerated;
    assign act.enable        = state_q.powerOn;
    assign act.sleepGuard    = state_q.sleepGuard;

    uopc_activity_tracker u_tracker (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .act      (act)
    );

    // Outputs
    assign regRdata             = state_q.rdata;
    assign dplusPullupEn        = state_q.resistorOut[3];
    assign dminusPullupEn       = state_q.resistorOut[2];
    assign dplusPulldownEn      = state_q.resistorOut[1];
    assign dminusPulldownEn     = state_q.resistorOut[0];
    assign busSupplyOn          = state_q.supplyOnOut;
    assign busSupplyChargeEn    = state_q.chargeOut;
    assign busSupplyDischargeEn = state_q.dischargeOut;
    assign usbClkEn             = state_q.clkEnOut;
    assign xcvrLowPower         = state_q.lowPowerOut;
    assign pinsUsbOwned         = state_q.pinsOwnedOut;
    assign analogEn             = state_q.analogOut;
    assign sleepBlock           = act.sleepBlock;

endmodule : uopc_top
`default_nettype wire

// ---- uopc_top_asserts.sv ----
// Checker for uopc_top: pin outputs against a shadow of the two registers.
// Assumes one core clock and the single-cycle register port of uopc_top.
`timescale 1ns/1ps
`default_nettype none
module uopc_top_asserts (
    input wire logic        core_clk,
    input wire logic        reset_n,
    input wire logic [7:0]  regAddr,
    input wire logic [31:0] regWdata,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [31:0] regRdata,
    input wire logic [3:0]  hwResistorCtl,
    input wire logic        busActivity,
    input wire logic        dplusPullupEn,
    input wire logic        dminusPulldownEn,
    input wire logic        busSupplyOn,
    input wire logic        busSupplyChargeEn,
    input wire logic        busSupplyDischargeEn,
    input wire logic        usbClkEn,
    input wire logic        xcvrLowPower,
    input wire logic        pinsUsbOwned,
    input wire logic        analogEn,
    input wire logic        sleepBlock
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    logic [7:0] otgQ;
    logic [7:0] pwrQ;
    wire        on = pwrQ[0];
    // Shadow of the writable bits, updated on the same edge as the design
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            otgQ <= 8'h00;
            pwrQ <= 8'h00;
        end else if (regWrite && regAddr == 8'h00) begin
            otgQ <= regWdata[7:0];
        end else if (regWrite && regAddr == 8'h04) begin
            pwrQ <= regWdata[7:0] & 8'h13;
        end
    end
    AST_DPLUS_PU: assert property (dplusPullupEn ==
        $past(on && (otgQ[2] ? otgQ[7] : hwResistorCtl[3]))) else $error("D+ pull-up wrong");
    AST_DMINUS_PD: assert property (dminusPulldownEn ==
        $past(on && (otgQ[2] ? otgQ[4] : hwResistorCtl[0]))) else $error("D- pull-down wrong");
    AST_SUPPLY: assert property (busSupplyOn == $past(on && otgQ[3]))
        else $error("supply wrong");
    AST_CHARGE: assert property (busSupplyChargeEn == $past(on && otgQ[1]))
        else $error("charge wrong");
    AST_DISCHARGE: assert property (busSupplyDischargeEn == $past(on && otgQ[0]))
        else $error("discharge wrong");
    AST_SUSPEND: assert property (usbClkEn == $past(on && !pwrQ[1])
        && xcvrLowPower == $past(!on || pwrQ[1])) else $error("suspend wrong");
    AST_OFF: assert property (!$past(on) |-> !analogEn && !pinsUsbOwned)
        else $error("off outputs active");
    AST_UPPER_ZERO: assert property (regRdata[31:8] == 24'h000000)
        else $error("upper bits set");
    AST_BUSY_ON: assert property (regRead && regAddr == 8'h04 && on |=> regRdata[3])
        else $error("busy low while on");
    AST_SLEEP_OPEN: assert property (!pwrQ[4] |-> !sleepBlock)
        else $error("sleep blocked without guard");
    AST_SLEEP_HOLD: assert property (pwrQ[4] && on && busActivity |-> sleepBlock)
        else $error("sleep not blocked");
endmodule : uopc_top_asserts
bind uopc_top uopc_top_asserts u_asserts (.core_clk, .reset_n, .regAddr, .regWdata,
    .regWrite, .regRead, .regRdata, .hwResistorCtl, .busActivity, .dplusPullupEn,
    .dminusPulldownEn, .busSupplyOn, .busSupplyChargeEn, .busSupplyDischargeEn,
    .usbClkEn, .xcvrLowPower, .pinsUsbOwned, .analogEn, .sleepBlock);
`default_nettype wire
